/* rtl/tpp_top.sv */
// Threshold PROM programming logic: serial interface on the supply pin,
// output pull-down entry, offset approximation, and fuse write control.
// Assumes supply_pin_i, q_in_i and field_above_i are asynchronous levels;
// the fuse array outside holds prom_rd_i stable from power-up.
//
// Overview of operation
// - Copy commands in calibrated mode store the calibrated threshold into PROM.
// - Two words: 101, five don't-care, three fraction bits, polarity, 1; then 101 ones.
// - Fraction bits are binary, first-listed bit most significant.
// - Polarity 0 inverts output switching; polarity 1 keeps it non-inverted.
// - Output held low at least 1 ms after power on enters interface mode.
// - Pull-down entry immediately runs offset DAC successive approximation.
// - Burn power comes through the output pin, not the supply.
// - Words arrive LSB first, 14 pulses per word; last 14 bits count.
// - A programmed device refuses both interface entry methods.
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
module tpp_top
   import tpp_pkg::*;
#(
   parameter int PULLDOWN_CYCLES = PULLDOWN_CYC,
   parameter int WORD_GAP_CYCLES = WORD_GAP_CYC,
   parameter int END_HIGH_CYCLES = END_HIGH_CYC,
   parameter int POR_CYCLES      = POR_WINDOW_CYC,
   parameter int SAR_DIV         = SAR_DIV_CYC,
   parameter int CNT_W           = 20
) (
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [3:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   input  wire logic             supply_pin_i,
   input  wire logic             q_in_i,
   output logic                  q_out_o,
   output logic                  q_oe_n_o,
   input  wire logic             field_above_i,
   input  wire logic             calibrated_i,
   input  wire logic [DAC_W-1:0] cal_threshold_i,
   input  wire tpp_prom_s        prom_rd_i,
   output tpp_prom_s             prom_wr_o,
   output logic                  prom_burn_o,
   output logic                  burn_from_q_o,
   output logic [DAC_W-1:0]      dac_o
);

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [1:0] sup_sync_reg, q_sync_reg, fld_sync_reg;
   logic       sup_prev_reg;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         sup_sync_reg <= 2'h0;
         q_sync_reg   <= 2'h3;
         fld_sync_reg <= 2'h0;
         sup_prev_reg <= 1'b0;
      end else begin
         sup_sync_reg <= {sup_sync_reg[0], supply_pin_i};
         q_sync_reg   <= {q_sync_reg[0], q_in_i};
         fld_sync_reg <= {fld_sync_reg[0], field_above_i};
         sup_prev_reg <= sup_sync_reg[1];
      end
   end

   wire sup_w    = sup_sync_reg[1];
   wire q_w      = q_sync_reg[1];
   wire field_w  = fld_sync_reg[1];
   wire sup_rise = sup_w & ~sup_prev_reg;

   // ---------------------------------------------------------------
   // State and fuse image
   // ---------------------------------------------------------------
   tpp_state_e       state_reg, state_next;
   tpp_prom_s        prom_reg;
   logic             loaded_reg;
   logic [CNT_W-1:0] por_cnt_reg, low_cnt_q_reg, burn_cnt_reg;
   logic             armed_reg;
   logic [2:0]       frac_reg;
   logic             pol_reg;
   logic             sync_req_reg;

   // Receiver
   logic [FRAME_BITS-1:0] shift_reg;
   logic [3:0]            nbits_reg;
   logic [CNT_W-1:0]      hi_cnt_reg, lo_cnt_reg;
   logic                  gap_seen_reg;

   // Approximation
   logic [DAC_W-1:0] dac_reg, sar_bit_reg;
   logic [CNT_W-1:0] sar_div_reg;
   logic             sar_busy_reg;

   // ---------------------------------------------------------------
   // Word decode
   // ---------------------------------------------------------------
   wire [DATA_BITS-1:0] word_w   = shift_reg[DATA_BITS-1:0];
   wire hdr_ok_w    = word_w[HDR_LSB +: 3] == HDR_CODE;
   wire word1_w     = hdr_ok_w & word_w[TAIL_POS];
   wire word2_w     = hdr_ok_w & (word_w[ONES_LSB +: 10] == ONES_CODE);
   wire [2:0] frac_w = {word_w[K2_POS], word_w[K1_POS], word_w[K0_POS]};
   wire gap_hit_w   = ~sup_w & (lo_cnt_reg == CNT_W'(WORD_GAP_CYCLES - 1));
   wire word_end_w  = gap_hit_w & ~gap_seen_reg & (nbits_reg == 4'(FRAME_BITS));
   wire end_high_w  = sup_w & (hi_cnt_reg == CNT_W'(END_HIGH_CYCLES - 1));
   wire in_iface_w  = state_reg == ST_IFACE;
   wire cmd_word2_w = in_iface_w & word_end_w & word2_w & armed_reg & ~prom_reg.programmed;
   wire pd_entry_w  = (state_reg == ST_POR) & ~prom_reg.programmed & loaded_reg
                      & (low_cnt_q_reg == CNT_W'(PULLDOWN_CYCLES - 1));
   wire sync_entry_w = sync_req_reg & ~prom_reg.programmed & loaded_reg
                      & ((state_reg == ST_POR) | (state_reg == ST_NORMAL));
   wire burn_done_w = (state_reg == ST_BURN) & (burn_cnt_reg == CNT_W'(BURN_CYC - 1));
   // Calibrated threshold when calibration finished, else the approximated level
   wire [DAC_W-1:0] copy_thr_w = calibrated_i ? cal_threshold_i : dac_reg;

   // ---------------------------------------------------------------
   // Mode sequencing
   // ---------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_POR: begin
            if (pd_entry_w | sync_entry_w)
               state_next = ST_IFACE;
            else if (loaded_reg & (por_cnt_reg == CNT_W'(POR_CYCLES - 1)))
               state_next = ST_NORMAL;
         end
         ST_NORMAL: begin
            if (sync_entry_w)
               state_next = ST_IFACE;
         end
         ST_IFACE: begin
            if (cmd_word2_w)
               state_next = ST_BURN;
            else if (end_high_w)
               state_next = ST_NORMAL;
         end
         ST_BURN: begin
            // Still in interface mode after burning so contents can be read
            if (burn_done_w)
               state_next = ST_IFACE;
         end
         default: state_next = ST_POR;
      endcase
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg     <= ST_POR;
         loaded_reg    <= 1'b0;
         por_cnt_reg   <= '0;
         low_cnt_q_reg <= '0;
         burn_cnt_reg  <= '0;
      end else begin
         state_reg     <= state_next;
         loaded_reg    <= 1'b1;
         por_cnt_reg   <= (state_reg == ST_POR) ? por_cnt_reg + 1'b1 : '0;
         low_cnt_q_reg <= (q_w | ~loaded_reg) ? '0 : low_cnt_q_reg + 1'b1;
         burn_cnt_reg  <= (state_reg == ST_BURN) ? burn_cnt_reg + 1'b1 : '0;
      end
   end

   // ---------------------------------------------------------------
   // Fuse image: captured after reset release, updated on burn
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         prom_reg  <= '0;
         armed_reg <= 1'b0;
         frac_reg  <= 3'h0;
         pol_reg   <= 1'b1;
      end else begin
         if (!loaded_reg)
            prom_reg <= prom_rd_i;
         else if (cmd_word2_w) begin
            prom_reg.programmed <= 1'b1;
            prom_reg.threshold  <= copy_thr_w;
            prom_reg.fraction   <= frac_reg;
            prom_reg.polarity   <= pol_reg;
         end
         if (!in_iface_w)
            armed_reg <= 1'b0;
         else if (word_end_w & word1_w & ~prom_reg.programmed) begin
            armed_reg <= 1'b1;
            frac_reg  <= frac_w;
            pol_reg   <= word_w[POL_POS];
         end else if (word_end_w & ~word2_w)
            armed_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Supply-pulse receiver: bit value from high versus low time
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_reg    <= '0;
         nbits_reg    <= 4'h0;
         hi_cnt_reg   <= '0;
         lo_cnt_reg   <= '0;
         gap_seen_reg <= 1'b0;
      end else if (!in_iface_w) begin
         nbits_reg    <= 4'h0;
         hi_cnt_reg   <= '0;
         lo_cnt_reg   <= '0;
         gap_seen_reg <= 1'b1;
      end else begin
         if (sup_rise) begin
            hi_cnt_reg <= '0;
            lo_cnt_reg <= '0;
            if (gap_seen_reg)
               gap_seen_reg <= 1'b0;
            else begin
               // LSB first; extra bits overwrite, the last 14 are kept
               shift_reg <= {(hi_cnt_reg > lo_cnt_reg), shift_reg[FRAME_BITS-1:1]};
               if (nbits_reg != 4'(FRAME_BITS))
                  nbits_reg <= nbits_reg + 4'h1;
            end
         end else if (sup_w) begin
            if (hi_cnt_reg != '1)
               hi_cnt_reg <= hi_cnt_reg + 1'b1;
         end else begin
            if (lo_cnt_reg != '1)
               lo_cnt_reg <= lo_cnt_reg + 1'b1;
            if (gap_hit_w) begin
               gap_seen_reg <= 1'b1;
               nbits_reg    <= 4'h0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Successive approximation of the offset DAC
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         dac_reg      <= '0;
         sar_bit_reg  <= '0;
         sar_div_reg  <= '0;
         sar_busy_reg <= 1'b0;
      end else if (pd_entry_w) begin
         dac_reg      <= DAC_W'(1) << (DAC_W - 1);
         sar_bit_reg  <= DAC_W'(1) << (DAC_W - 1);
         sar_div_reg  <= '0;
         sar_busy_reg <= 1'b1;
      end else if (sar_busy_reg) begin
         if (sar_div_reg == CNT_W'(SAR_DIV - 1)) begin
            sar_div_reg <= '0;
            // Field still above the trial level keeps the bit set
            if (field_w)
               dac_reg <= dac_reg | (sar_bit_reg >> 1);
            else
               dac_reg <= (dac_reg & ~sar_bit_reg) | (sar_bit_reg >> 1);
            sar_bit_reg <= sar_bit_reg >> 1;
            if (sar_bit_reg == DAC_W'(1))
               sar_busy_reg <= 1'b0;
         end else
            sar_div_reg <= sar_div_reg + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Open-drain output and fuse write outputs
   // ---------------------------------------------------------------
   // Unprogrammed parts behave non-inverted
   wire eff_pol_w  = prom_reg.programmed ? prom_reg.polarity : 1'b1;
   wire drive_lo_w = (state_reg == ST_NORMAL) & ~(field_w ^ eff_pol_w);

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         q_out_o       <= 1'b0;
         q_oe_n_o      <= 1'b1;
         prom_wr_o     <= '0;
         prom_burn_o   <= 1'b0;
         burn_from_q_o <= 1'b0;
         dac_o         <= '0;
      end else begin
         q_out_o       <= 1'b0;
         q_oe_n_o      <= ~drive_lo_w;
         prom_wr_o     <= prom_reg;
         prom_burn_o   <= state_reg == ST_BURN;
         burn_from_q_o <= state_reg == ST_BURN;
         dac_o         <= dac_reg;
      end
   end

   // ---------------------------------------------------------------
   // Wishbone classic slave
   // ---------------------------------------------------------------
   wire        wb_req_w  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        wb_wr_w   = wb_req_w & wb_we_i & wb_sel_i[0];
   wire [31:0] stat_w    = {26'h0, sar_busy_reg, state_reg, prom_reg.programmed};
   wire [31:0] prom_w    = {19'h0, prom_reg.programmed, prom_reg.polarity,
                            prom_reg.fraction, prom_reg.threshold};
   wire [31:0] rd_w      = (wb_adr_i == REG_STATUS) ? stat_w :
                           (wb_adr_i == REG_PROM)   ? prom_w :
                           (wb_adr_i == REG_DAC)    ? {24'h0, dac_reg} : 32'h0;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         wb_ack_o     <= 1'b0;
         wb_dat_o     <= 32'h0;
         sync_req_reg <= 1'b0;
      end else begin
         wb_ack_o     <= wb_req_w;
         wb_dat_o     <= (wb_req_w & ~wb_we_i) ? rd_w : 32'h0;
         // Self-clearing trigger for the sync entry written through REG_CTRL
         sync_req_reg <= wb_wr_w & (wb_adr_i == REG_CTRL) & wb_dat_i[CTRL_SYNC];
      end
   end

endmodule // tpp_top

/* rtl/tpp_pkg.sv */
// Shared constants and types for the threshold PROM programming block.
// Assumes a 250 MHz system clock; the Wishbone bus uses 32-bit data.
package tpp_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 4;
   localparam int PULLDOWN_MIN_NS = 1000000;   // Least output pull-down for entry
   localparam int WORD_GAP_NS     = 200000;    // Least low level that ends a word
   localparam int END_HIGH_NS     = 1000000;   // Least high level that ends a session
   localparam int POR_WINDOW_NS   = 2000000;   // Time the output is watched after reset
   // Least times round up to whole cycles
   localparam int PULLDOWN_CYC    = (PULLDOWN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WORD_GAP_CYC    = (WORD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int END_HIGH_CYC    = (END_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POR_WINDOW_CYC  = (POR_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SAR_DIV_CYC     = 64;        // Internal clock period in system cycles
   localparam int BURN_CYC        = 1000;      // Fuse burn duration

   // ---------------------------------------------------------------
   // Serial word layout (bit 0 is the first received)
   // ---------------------------------------------------------------
   localparam int          FRAME_BITS  = 14;
   localparam int          DATA_BITS   = 13;
   localparam logic [2:0]  HDR_CODE    = 3'h5;   // 1,0,1 in arrival order
   localparam int          HDR_LSB     = 0;
   localparam int          K2_POS      = 8;
   localparam int          K1_POS      = 9;
   localparam int          K0_POS      = 10;
   localparam int          POL_POS     = 11;
   localparam int          TAIL_POS    = 12;
   localparam int          ONES_LSB    = 3;
   localparam logic [9:0]  ONES_CODE   = 10'h3FF;

   // ---------------------------------------------------------------
   // Register map (byte addresses) and fields
   // ---------------------------------------------------------------
   localparam int          DAC_W       = 8;
   localparam logic [3:0]  REG_CTRL    = 4'h0;
   localparam logic [3:0]  REG_STATUS  = 4'h4;
   localparam logic [3:0]  REG_PROM    = 4'h8;
   localparam logic [3:0]  REG_DAC     = 4'hC;
   localparam int          CTRL_SYNC   = 0;
   localparam int          PROM_FRAC_LSB = 8;
   localparam int          PROM_POL    = 11;
   localparam int          PROM_DONE   = 12;

   typedef struct packed {
      logic             programmed;
      logic             polarity;
      logic [2:0]       fraction;
      logic [DAC_W-1:0] threshold;
   } tpp_prom_s;

   typedef enum logic [3:0] {
      ST_POR    = 4'h1,
      ST_NORMAL = 4'h2,
      ST_IFACE  = 4'h4,
      ST_BURN   = 4'h8
   } tpp_state_e;

endpackage

/* bench/tpp_prog_model.sv */
// Programmer model: supply pulse words, output pull-down, field source.
// Assumes the bench clock paces it; the bench models the Q pull-up.
`timescale 1ns/100ps
module tpp_prog_model
   import tpp_pkg::*;
#(
   parameter logic [DAC_W-1:0] TARGET = 8'h5A
) (
   input  wire logic             clk_i,
   input  wire logic [DAC_W-1:0] dac_i,
   output logic                  supply_o,
   output logic                  q_pull_o,
   output logic                  field_above_o
);
   logic field_sar = 1'b1;
   logic field_lvl = 1'b0;
   initial begin
      supply_o = 1'b0;
      q_pull_o = 1'b0;
   end
   // Comparator tracks the DAC so the approximation settles on TARGET
   assign field_above_o = field_sar ? (dac_i <= TARGET) : field_lvl;
   task automatic pulse(input int hi, input int lo);
      supply_o <= 1'b1;
      repeat (hi) @(posedge clk_i);
      supply_o <= 1'b0;
      repeat (lo) @(posedge clk_i);
   endtask
   // LSB first, 2/3 high is a one; the 15th edge closes bit 13
   task automatic send_word(input logic [13:0] w);
      for (int i = 0; i < 14; i++) begin
         pulse(w[i] ? 21 : 10, w[i] ? 10 : 21);
      end
      pulse(8, 260);
   endtask
   task automatic end_session();
      pulse(420, 1);
   endtask
   task automatic pull_q(input int n);
      q_pull_o <= 1'b1;
      repeat (n) @(posedge clk_i);
      q_pull_o <= 1'b0;
   endtask
endmodule // tpp_prog_model

/* bench/tpp_top_monitor.sv */
// Checker for the PROM programming block, bound to its top module.
// Assumes one clock domain and sees the top module's ports only.
`timescale 1ns/100ps
module tpp_top_monitor
   import tpp_pkg::*;
(
   input wire logic             mclk_i,
   input wire logic             rst_i,
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_ack_o,
   input wire logic [31:0]      wb_dat_o,
   input wire logic             supply_pin_i,
   input wire logic             q_oe_n_o,
   input wire logic             calibrated_i,
   input wire logic [DAC_W-1:0] cal_threshold_i,
   input wire tpp_prom_s        prom_rd_i,
   input wire tpp_prom_s        prom_wr_o,
   input wire logic             prom_burn_o,
   input wire logic             burn_from_q_o
);
   int burn_cnt;
   // Burn is far too long for a repetition, so count it
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         burn_cnt <= 0;
      end else begin
         burn_cnt <= prom_burn_o ? burn_cnt + 1 : 0;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_data_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack cycle");
   a_burn_power: assert property (burn_from_q_o == prom_burn_o)
      else $error("burn power not taken from output");
   a_burn_released: assert property (prom_burn_o |-> q_oe_n_o)
      else $error("output driven during burn");
   a_burn_length: assert property ($fell(prom_burn_o) |-> burn_cnt == BURN_CYC)
      else $error("burn length wrong");
   a_image_steady: assert property (prom_burn_o && $past(prom_burn_o) |->
      $stable(prom_wr_o) && prom_wr_o.programmed) else $error("fuse image moved in burn");
   a_copy_cal: assert property ($rose(prom_burn_o) && calibrated_i |->
      prom_wr_o.threshold == cal_threshold_i) else $error("calibrated value not copied");
   a_word_gap: assert property ($rose(prom_burn_o) |-> !$past(supply_pin_i, 8))
      else $error("burn without word gap");
   a_fuse_locked: assert property (prom_rd_i.programmed |-> !prom_burn_o)
      else $error("programmed part burned again");
   c_burn_start: cover property ($rose(prom_burn_o));
   c_burn_end: cover property ($fell(prom_burn_o));
   c_read_data: cover property (wb_ack_o && wb_dat_o != 32'h0);
endmodule // tpp_top_monitor
bind tpp_top tpp_top_monitor tpp_top_monitor_i (
   .mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .supply_pin_i(supply_pin_i),
   .q_oe_n_o(q_oe_n_o), .calibrated_i(calibrated_i), .cal_threshold_i(cal_threshold_i),
   .prom_rd_i(prom_rd_i), .prom_wr_o(prom_wr_o), .prom_burn_o(prom_burn_o),
   .burn_from_q_o(burn_from_q_o));

/* bench/tpp_top_tb.sv */
// Self-checking bench for the threshold PROM programming block.
// Assumes the programmer model drives supply and Q; Q has a pull-up.
`timescale 1ns/100ps
module tpp_top_tb;
   import tpp_pkg::*;
   // Same as the programmer model's default target
   localparam logic [DAC_W-1:0] TARGET = 8'h5A;
   logic             mclk_i = 1'b0;
   logic             rst_i = 1'b1;
   logic             cyc = 1'b0;
   logic             we = 1'b0;
   logic [3:0]       sel = 4'hF;
   logic [3:0]       adr = 4'h0;
   logic [31:0]      wdat = 32'h0;
   logic [31:0]      rdat, st;
   logic             ack, supply, q_pull, q_in, q_out, q_oe_n, field_above, burn, burn_q;
   logic             calibrated = 1'b0;
   logic [DAC_W-1:0] cal_thr = 8'h00;
   logic [DAC_W-1:0] dac;
   tpp_prom_s        prom_rd = '0;
   tpp_prom_s        prom_wr;
   int               fail_count = 0;
   int               tests_run = 0;

   always #2 mclk_i = ~mclk_i;
   // Open drain: high unless the device or the programmer pulls low
   assign q_in = (q_oe_n | q_out) & ~q_pull;

   tpp_top #(.PULLDOWN_CYCLES(20), .WORD_GAP_CYCLES(200), .END_HIGH_CYCLES(400),
      .POR_CYCLES(100), .SAR_DIV(4)) tpp_top_i (
      .mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .supply_pin_i(supply), .q_in_i(q_in), .q_out_o(q_out), .q_oe_n_o(q_oe_n),
      .field_above_i(field_above), .calibrated_i(calibrated), .cal_threshold_i(cal_thr),
      .prom_rd_i(prom_rd), .prom_wr_o(prom_wr), .prom_burn_o(burn),
      .burn_from_q_o(burn_q), .dac_o(dac));
   tpp_prog_model tpp_prog_model_i (.clk_i(mclk_i), .dac_i(dac),
      .supply_o(supply), .q_pull_o(q_pull), .field_above_o(field_above));

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
         fail_count++;
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Classic single cycle; request held until ack is seen at an edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge mclk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      st = rdat;
      cyc <= 1'b0;
      if (ack !== 1'b1) begin
         chk("bus ack", ack, 32'h1);
         results();
      end
      @(posedge mclk_i);
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                         input string name);
      bus(1'b0, a, 32'h0);
      chk(name, st & m, e);
   endtask
   task automatic do_reset(input logic pull);
      rst_i <= 1'b1;
      repeat (6) @(posedge mclk_i);
      rst_i <= 1'b0;
      if (pull) tpp_prog_model_i.pull_q(30);
   endtask
   task automatic send_pair(input logic [2:0] k, input logic pol);
      tpp_prog_model_i.send_word({2'h3, pol, k[0], k[1], k[2], 5'h1A, 3'h5});
      tpp_prog_model_i.send_word(14'h3FFD);
   endtask
   // Fraction and polarity are chosen before the words go out
   task automatic burn_flow(input logic [2:0] k, input logic pol, input logic [7:0] thr);
      int n;
      n = 0;
      send_pair(k, pol);
      chk("burn", burn, 32'h1);
      chk("burn power", burn_q, 32'h1);
      chk("fuse image", prom_wr, {1'b1, pol, k, thr});
      while (burn === 1'b1 && n < 1200) begin
         @(posedge mclk_i);
         n++;
      end
      chk("burn end", burn, 32'h0);
      if (burn !== 1'b0) results();
      rd_chk(REG_STATUS, 32'h1E, 32'h08, "iface after burn");
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      do_reset(1'b0);
      rd_chk(REG_STATUS, 32'hFFFFFFFF, 32'h02, "status reset");
      bus(1'b1, REG_STATUS, 32'hFFFFFFFF);
      rd_chk(REG_STATUS, 32'hFFFFFFFF, 32'h02, "status read only");
      rd_chk(REG_PROM, 32'hFFFFFFFF, 32'h0, "prom reset");
      rd_chk(REG_DAC, 32'hFFFFFFFF, 32'h0, "dac reset");
      rd_chk(REG_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl reads zero");
      rd_chk(4'h2, 32'hFFFFFFFF, 32'h0, "unmapped");
      $display("test regs done");
   endtask
   task automatic t_pulldown();
      do_reset(1'b1);
      repeat (60) @(posedge mclk_i);
      rd_chk(REG_STATUS, 32'h3E, 32'h08, "pulldown entry");
      rd_chk(REG_DAC, 32'hFF, TARGET, "approximation");
      chk("dac out", dac, TARGET);
      burn_flow(3'h3, 1'b1, TARGET);
      send_pair(3'h5, 1'b0);
      chk("no second burn", burn, 32'h0);
      tpp_prog_model_i.end_session();
      rd_chk(REG_STATUS, 32'h1E, 32'h04, "session end");
      $display("test pulldown done");
   endtask
   task automatic t_sync();
      do_reset(1'b0);
      // Trigger sits in byte lane 0; a write without that lane is ignored
      sel <= 4'hE;
      bus(1'b1, REG_CTRL, 32'h1);
      sel <= 4'hF;
      rd_chk(REG_STATUS, 32'h1E, 32'h02, "lane 0 off");
      bus(1'b1, REG_CTRL, 32'h1);
      rd_chk(REG_STATUS, 32'h1E, 32'h08, "sync entry");
      calibrated <= 1'b1;
      cal_thr <= 8'hA5;
      burn_flow(3'h7, 1'b0, 8'hA5);
      calibrated <= 1'b0;
      $display("test sync done");
   endtask
   task automatic t_locked();
      for (int p = 0; p < 2; p++) begin
         prom_rd <= {1'b1, p[0], 3'h2, 8'h40};
         do_reset(1'b1);
         repeat (100) @(posedge mclk_i);
         bus(1'b1, REG_CTRL, 32'h1);
         rd_chk(REG_STATUS, 32'h1F, 32'h05, "entry refused");
         rd_chk(REG_PROM, 32'h1FFF, {19'h0, 1'b1, p[0], 3'h2, 8'h40}, "prom image");
         tpp_prog_model_i.field_sar <= 1'b0;
         for (int f = 0; f < 2; f++) begin
            tpp_prog_model_i.field_lvl <= f[0];
            repeat (8) @(posedge mclk_i);
            chk("output level", q_oe_n, {31'h0, f[0] ^ p[0]});
            chk("output data", q_out, 32'h0);
         end
         tpp_prog_model_i.field_sar <= 1'b1;
      end
      $display("test locked done");
   endtask
   initial begin
      t_regs();
      t_pulldown();
      t_sync();
      t_locked();
      results();
   end
endmodule // tpp_top_tb
